/* pvh_pkg.sv */
package pvh_pkg;
   // ********************************************
   // Register map and field layout
   // ********************************************
   localparam int PVH_DW = 32;
   localparam logic [3:0] PVH_OFF_METER = 4'h0;
   localparam logic [3:0] PVH_OFF_DATA = 4'h4;
   localparam logic [3:0] PVH_OFF_ADDR = 4'h8;
   localparam logic [3:0] PVH_OFF_STAT = 4'hC;
   localparam int PVH_AB_CODE = 31;
   localparam int PVH_LOC_AW = 23;
   localparam int PVH_SB_STD50 = 5;
   localparam int PVH_SB_MVERR = 7;
   localparam int PVH_SB_VEC = 8;
   localparam int PVH_SB_IRQEN = 19;
   localparam logic [31:0] PVH_ADDR_RST = 32'h0000_0000;
   localparam logic [7:0] PVH_VEC_RST = 8'h00;
   // ********************************************
   // Code buffer, memory and picture geometry
   // ********************************************
   localparam int PVH_BUF_AW = 18;
   localparam int PVH_DRAM_PAGE_AW = 18;
   localparam logic [9:0] PVH_LINE_PELS = 10'h2C4;
   localparam logic [9:0] PVH_LINES_60 = 10'h1E0;
   localparam logic [9:0] PVH_LINES_50 = 10'h240;
   localparam logic [3:0] PVH_SEGS_60 = 4'h9;
   localparam logic [3:0] PVH_SEGS_50 = 4'hA;
   localparam int PVH_STAGES = 5;
   // ********************************************
   // Search limits in half-element units
   // ********************************************
   localparam logic signed [9:0] PVH_P_HMIN = 10'sh32C;
   localparam logic signed [9:0] PVH_P_HMAX = 10'sh0C7;
   localparam logic signed [9:0] PVH_B_HMIN = 10'sh36C;
   localparam logic signed [9:0] PVH_B_HMAX = 10'sh087;
   localparam logic signed [9:0] PVH_VMIN = 10'sh38C;
   localparam logic signed [9:0] PVH_VMAX = 10'sh067;
   typedef enum logic [1:0] {
      PVH_S_IDLE = 2'b00,
      PVH_S_LOC = 2'b01,
      PVH_S_ACK = 2'b10
   } pvh_wb_state_t;
endpackage : pvh_pkg

/* pvh_cbuf_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Joins the host port to its code buffer store
interface pvh_cbuf_if #(parameter int DW = 32, parameter int AW = 18);
   logic push;
   logic [DW-1:0] push_data;
   logic pop;
   logic [DW-1:0] pop_data;
   logic [AW:0] level;
   logic full;
   logic empty;
   modport store (input push, push_data, pop,
                  output pop_data, level, full, empty);
   modport user (output push, push_data, pop,
                 input pop_data, level, full, empty);
endinterface : pvh_cbuf_if
`default_nettype wire

/* pvh_code_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module pvh_code_buffer
   import pvh_pkg::*;
#(
   parameter int DW = PVH_DW,
   parameter int AW = PVH_BUF_AW
) (
   input wire logic clock,
   input wire logic rst_n,
   pvh_cbuf_if.store cb
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] level_r;
   logic do_push;
   logic do_pop;

   // Overfill and underrun are refused here, whatever the user does
   assign do_push = cb.push && !cb.full;
   assign do_pop = cb.pop && !cb.empty;
   assign cb.full = level_r[AW];
   assign cb.empty = (level_r == '0);
   assign cb.level = level_r;
   assign cb.pop_data = mem[rd_r];

   // Storage has no reset; only the pointers define content
   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[wr_r] <= cb.push_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_r <= '0;
         rd_r <= '0;
         level_r <= '0;
      end else begin
         if (do_push) wr_r <= wr_r + 1'b1;
         if (do_pop) rd_r <= rd_r + 1'b1;
         if (do_push && !do_pop) level_r <= level_r + 1'b1;
         else if (do_pop && !do_push) level_r <= level_r - 1'b1;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_level_bound: assert property (
      !(level_r[AW] && (level_r[AW-1:0] != '0)))
      else $error("code buffer level above capacity");
   chk_level_push: assert property (
      (do_push && !do_pop) |=> level_r == $past(level_r) + 1'b1)
      else $error("fill level did not rise on push");
endmodule : pvh_code_buffer
`default_nettype wire

/* pvh_host_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Accept YCbCr samples on the input bus, frames of 708 by 480 or 576.
// - Input, output and host buses fan out alike to all processors.
// - Compressed words fill a 1 Mbyte code buffer the host drains.
// - Local bus reaches four registers the host can also reach.
// - Meter register shows the current code buffer fill level.
// - Data register moves words host to local bus and back.
// - Status register holds encoder-set status, readable by the host.
// - Raise vectored host interrupts with a host-readable vector.
// - Five concurrent pipeline stages, each one frame time long.
// - Picture split horizontally: nine segments 60-field, ten 50-field.
// - Capture keeps both fields, 480 or 576 lines.
// - Third frame time: motion vector and score per macroblock.
// - Fourth frame time: DCT or difference coding, then VLC.
// - Fifth frame time: slices go out and merge in the buffer.
// - Each processor owns two pages of 256K words of DRAM.
// - Predicted search: -106/+99.5 horizontal, -58/+51.5 vertical.
// - Bidirectional search: -74/+67.5 horizontal, -58/+51.5 vertical.
module pvh_host_port
   import pvh_pkg::*;
#(
   parameter int BUF_AW = PVH_BUF_AW
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic vin_valid,
   input wire logic [15:0] vin_data,
   output logic [3:0] seg_owner,
   output logic frame_tick,
   output logic [PVH_STAGES-1:0] stage,
   input wire logic cob_valid,
   input wire logic [31:0] cob_data,
   output logic cob_ready,
   output logic loc_req,
   output logic loc_we,
   output logic [PVH_LOC_AW-1:0] loc_addr,
   output logic [31:0] loc_wdata,
   input wire logic [31:0] loc_rdata,
   input wire logic loc_ack,
   input wire logic pw_valid,
   input wire logic [31:0] pw_data,
   output logic pw_ready,
   input wire logic irq_req,
   output logic host_irq,
   output logic [7:0] irq_vec,
   input wire logic mv_valid,
   input wire logic mv_bidir,
   input wire logic signed [9:0] mv_h,
   input wire logic signed [9:0] mv_v
);
   // ********************************************
   // Declarations
   // ********************************************
   localparam logic [BUF_AW:0] LVL_HI = (BUF_AW+1)'((1 << BUF_AW) - 1);
   pvh_wb_state_t st_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic [31:0] addr_r;
   logic std50_r;
   logic irq_en_r;
   logic mverr_r;
   logic [7:0] vec_r;
   logic mbox_r;
   logic mbox_nxt;
   logic [31:0] mbox_dat_r;
   logic pw_ready_r;
   logic loc_req_r;
   logic loc_we_r;
   logic [PVH_LOC_AW-1:0] loc_addr_r;
   logic [31:0] loc_wdata_r;
   logic host_irq_r;
   logic cob_ready_r;
   logic [9:0] pel_r;
   logic [9:0] line_r;
   logic [9:0] acc_r;
   logic [9:0] acc_sum;
   logic [9:0] lines;
   logic [3:0] segs;
   logic [3:0] seg_r;
   logic frame_tick_r;
   logic frame_end;
   logic [PVH_STAGES-1:0] stage_r;
   logic start;
   logic rd_code;
   logic rd_mbox;
   logic loc_go;
   logic wr_addr;
   logic wr_stat;
   logic mv_bad;
   logic signed [9:0] hmin;
   logic signed [9:0] hmax;
   logic [31:0] stat_val;
   logic [31:0] meter_val;

   pvh_cbuf_if #(.DW(PVH_DW), .AW(BUF_AW)) cb ();

   pvh_code_buffer #(.DW(PVH_DW), .AW(BUF_AW)) u_buf (
      .clock (clock),
      .rst_n (rst_n),
      .cb (cb.store)
   );

   // ********************************************
   // Bus decode
   // ********************************************
   // A new request is only looked at in idle, so a held strobe
   // after the acknowledge is never taken twice
   assign start = wb_cyc_i && wb_stb_i && (st_r == PVH_S_IDLE);
   assign rd_code = start && !wb_we_i && (wb_adr_i == PVH_OFF_DATA)
                    && addr_r[PVH_AB_CODE];
   assign rd_mbox = start && !wb_we_i && (wb_adr_i == PVH_OFF_DATA)
                    && !addr_r[PVH_AB_CODE] && mbox_r;
   assign loc_go = start && (wb_adr_i == PVH_OFF_DATA)
                   && !addr_r[PVH_AB_CODE] && (wb_we_i || !mbox_r);
   assign wr_addr = start && wb_we_i && (wb_adr_i == PVH_OFF_ADDR);
   assign wr_stat = start && wb_we_i && (wb_adr_i == PVH_OFF_STAT);
   assign meter_val = 32'(cb.level);
   assign stat_val = {12'h000, irq_en_r, host_irq_r, cb.empty, cb.full,
                      vec_r, mverr_r, mbox_r, std50_r, stage_r};

   // Bus state: register, code and mailbox hits answer at once, local transfers wait
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= PVH_S_IDLE;
      end else begin
         case (st_r)
            PVH_S_IDLE: if (start) st_r <= loc_go ? PVH_S_LOC : PVH_S_ACK;
            PVH_S_LOC: if (loc_ack) st_r <= PVH_S_ACK;
            PVH_S_ACK: st_r <= PVH_S_IDLE;
            default: st_r <= PVH_S_IDLE;
         endcase
      end
   end

   // Acknowledge is high for exactly one cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (start && !loc_go) || ((st_r == PVH_S_LOC) && loc_ack);
      end
   end

   // Read data; unmapped offsets read zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dat_r <= 32'h0000_0000;
      end else if (start && !wb_we_i) begin
         case (wb_adr_i)
            PVH_OFF_METER: dat_r <= meter_val;
            PVH_OFF_DATA: dat_r <= rd_code ? cb.pop_data : mbox_dat_r;
            PVH_OFF_ADDR: dat_r <= addr_r;
            PVH_OFF_STAT: dat_r <= stat_val;
            default: dat_r <= 32'h0000_0000;
         endcase
      end else if ((st_r == PVH_S_LOC) && loc_ack && !loc_we_r) begin
         dat_r <= loc_rdata;
      end
   end

   // ********************************************
   // Host-written registers
   // ********************************************
   // Address register, byte lanes honoured
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= PVH_ADDR_RST;
      end else if (wr_addr) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) addr_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
         end
      end
   end

   // Configuration fields of the status register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         std50_r <= 1'b0;
         vec_r <= PVH_VEC_RST;
         irq_en_r <= 1'b0;
      end else if (wr_stat) begin
         if (wb_sel_i[0]) std50_r <= wb_dat_i[PVH_SB_STD50];
         if (wb_sel_i[1]) vec_r <= wb_dat_i[PVH_SB_VEC +: 8];
         if (wb_sel_i[2]) irq_en_r <= wb_dat_i[PVH_SB_IRQEN];
      end
   end

   // ********************************************
   // Local bus and processor mailbox
   // ********************************************
   // One local transfer at a time, held until the processors answer;
   // the target is whatever the address register held beforehand
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         loc_req_r <= 1'b0;
         loc_we_r <= 1'b0;
         loc_addr_r <= '0;
         loc_wdata_r <= 32'h0000_0000;
      end else if (loc_go) begin
         loc_req_r <= 1'b1;
         loc_we_r <= wb_we_i;
         loc_addr_r <= addr_r[PVH_LOC_AW-1:0];
         loc_wdata_r <= wb_dat_i;
      end else if (loc_ack) begin
         loc_req_r <= 1'b0;
      end
   end

   // A processor word waits here until the host reads the data window;
   // an arrival in the clearing cycle wins
   always_comb begin
      mbox_nxt = mbox_r;
      if (pw_valid && pw_ready_r) mbox_nxt = 1'b1;
      else if (rd_mbox) mbox_nxt = 1'b0;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mbox_r <= 1'b0;
         mbox_dat_r <= 32'h0000_0000;
         pw_ready_r <= 1'b0;
      end else begin
         mbox_r <= mbox_nxt;
         if (pw_valid && pw_ready_r) mbox_dat_r <= pw_data;
         pw_ready_r <= !mbox_nxt;
      end
   end

   // ********************************************
   // Code buffer fill and drain
   // ********************************************
   assign cb.push = cob_valid && cob_ready_r;
   assign cb.push_data = cob_data;
   assign cb.pop = rd_code;

   // Ready looks one word ahead, as it is a registered output
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cob_ready_r <= 1'b0;
      end else begin
         cob_ready_r <= (cb.level < LVL_HI);
      end
   end

   // ********************************************
   // Capture geometry and pipeline
   // ********************************************
   assign lines = std50_r ? PVH_LINES_50 : PVH_LINES_60;
   assign segs = std50_r ? PVH_SEGS_50 : PVH_SEGS_60;
   assign acc_sum = acc_r + 10'(segs);
   assign frame_end = vin_valid && (pel_r == PVH_LINE_PELS - 10'h001)
                      && (line_r == lines - 10'h001);

   // Pel and line count; segment steps spread lines evenly, so the
   // standard should only change between frames
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pel_r <= '0;
         line_r <= '0;
         acc_r <= '0;
         seg_r <= '0;
      end else if (vin_valid) begin
         if (pel_r != PVH_LINE_PELS - 10'h001) begin
            pel_r <= pel_r + 10'h001;
         end else if (frame_end) begin
            pel_r <= '0;
            line_r <= '0;
            acc_r <= '0;
            seg_r <= '0;
         end else begin
            pel_r <= '0;
            line_r <= line_r + 10'h001;
            if (acc_sum >= lines) begin
               acc_r <= acc_sum - lines;
               seg_r <= seg_r + 4'h1;
            end else begin
               acc_r <= acc_sum;
            end
         end
      end
   end

   // Frame time boundary; each stage bit marks a frame in flight:
   // capture, preprocess, motion search, coding, output
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         frame_tick_r <= 1'b0;
         stage_r <= '0;
      end else begin
         frame_tick_r <= frame_end;
         if (frame_end) begin
            stage_r <= {stage_r[PVH_STAGES-2:0], 1'b1};
         end
      end
   end

   // ********************************************
   // Motion search check and interrupt
   // ********************************************
   assign hmin = mv_bidir ? PVH_B_HMIN : PVH_P_HMIN;
   assign hmax = mv_bidir ? PVH_B_HMAX : PVH_P_HMAX;
   assign mv_bad = mv_valid && ((mv_h < hmin) || (mv_h > hmax)
                   || (mv_v < PVH_VMIN) || (mv_v > PVH_VMAX));

   // Sticky range error, write one to clear, new error wins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mverr_r <= 1'b0;
      end else if (mv_bad) begin
         mverr_r <= 1'b1;
      end else if (wr_stat && wb_sel_i[0] && wb_dat_i[PVH_SB_MVERR]) begin
         mverr_r <= 1'b0;
      end
   end

   // Processor requests pass to the host with its vector
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         host_irq_r <= 1'b0;
      end else begin
         host_irq_r <= irq_req && irq_en_r;
      end
   end

   // ********************************************
   // Outputs
   // ********************************************
   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign seg_owner = seg_r;
   assign frame_tick = frame_tick_r;
   assign stage = stage_r;
   assign cob_ready = cob_ready_r;
   assign loc_req = loc_req_r;
   assign loc_we = loc_we_r;
   assign loc_addr = loc_addr_r;
   assign loc_wdata = loc_wdata_r;
   assign pw_ready = pw_ready_r;
   assign host_irq = host_irq_r;
   assign irq_vec = vec_r;

   // ********************************************
   // Checks
   // ********************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_reg_req;
      start && !loc_go;
   endsequence
   sequence s_ack_pulse;
      ack_r ##1 !ack_r;
   endsequence
   chk_reg_ack_pulse: assert property (s_reg_req |=> s_ack_pulse)
      else $error("register access not acknowledged for one cycle");
   chk_loc_hold: assert property (
      (loc_req_r && !loc_ack) |=> loc_req_r && $stable(loc_addr_r))
      else $error("local request dropped before answer");
   chk_loc_addr_src: assert property (
      loc_go |=> loc_addr_r == $past(addr_r[PVH_LOC_AW-1:0]))
      else $error("local address not from address register");
   chk_meter_read: assert property (
      (start && !wb_we_i && wb_adr_i == PVH_OFF_METER)
      |=> wb_dat_o == $past(meter_val) && wb_ack_o)
      else $error("meter read wrong");
   chk_frame_len: assert property (
      frame_tick_r |-> $past(pel_r) == PVH_LINE_PELS - 10'h001
      && $past(line_r) == lines - 10'h001)
      else $error("frame size wrong");
   chk_seg_count: assert property (frame_end |-> seg_r == segs - 4'h1)
      else $error("segment count wrong at frame end");
   chk_stage_shift: assert property (
      frame_end |=> stage_r[0] && stage_r[4:1] == $past(stage_r[3:0]))
      else $error("pipeline stages did not advance");
   chk_mv_flag: assert property (mv_bad |=> mverr_r)
      else $error("search range error not flagged");
   chk_irq_pass: assert property (
      (irq_req && irq_en_r) |=> host_irq && irq_vec == $past(vec_r))
      else $error("interrupt not raised");
   chk_cob_nofull: assert property (cb.full |-> !cob_ready_r)
      else $error("ready while code buffer full");
endmodule : pvh_host_port
`default_nettype wire

/* pvh_local_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Stands for the encoding processors behind the local bus
module pvh_local_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] lat,
   input wire logic loc_req,
   input wire logic loc_we,
   input wire logic [22:0] loc_addr,
   input wire logic [31:0] loc_wdata,
   output logic [31:0] loc_rdata,
   output logic loc_ack
);
   logic [31:0] mem_r [16];
   logic [3:0] wait_r;
   // Answer after lat cycles; data toggles while idle so that
   // a stale word can never pass for a fresh one
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 4'h0;
         loc_ack <= 1'b0;
         loc_rdata <= 32'h0;
      end else begin
         loc_ack <= 1'b0;
         loc_rdata <= ~loc_rdata;
         if (loc_req && !loc_ack) begin
            if (wait_r == lat) begin
               wait_r <= 4'h0;
               loc_ack <= 1'b1;
               if (loc_we) begin
                  mem_r[loc_addr[3:0]] <= loc_wdata;
               end else begin
                  loc_rdata <= mem_r[loc_addr[3:0]];
               end
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule : pvh_local_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pvh_pkg::*;
   // ********
   // Signals
   // ********
   logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] wb_adr_i, wb_sel_i, seg_owner, lat;
   logic [31:0] wb_dat_i, wb_dat_o, cob_data, loc_wdata, loc_rdata;
   logic [31:0] pw_data, q;
   logic vin_valid, frame_tick, cob_valid, cob_ready, loc_req;
   logic loc_we, loc_ack, pw_valid, pw_ready, irq_req, host_irq;
   logic mv_valid, mv_bidir;
   logic [15:0] vin_data;
   logic [PVH_STAGES-1:0] stage;
   logic [PVH_LOC_AW-1:0] loc_addr;
   logic [7:0] irq_vec;
   logic signed [9:0] mv_h, mv_v;
   int err_total, check_count;
   // Small buffer keeps the fill scenario short
   pvh_host_port #(.BUF_AW(4)) u_pvh_host_port (
      .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .vin_valid(vin_valid), .vin_data(vin_data),
      .seg_owner(seg_owner), .frame_tick(frame_tick), .stage(stage),
      .cob_valid(cob_valid), .cob_data(cob_data), .cob_ready(cob_ready),
      .loc_req(loc_req), .loc_we(loc_we), .loc_addr(loc_addr),
      .loc_wdata(loc_wdata), .loc_rdata(loc_rdata), .loc_ack(loc_ack),
      .pw_valid(pw_valid), .pw_data(pw_data), .pw_ready(pw_ready),
      .irq_req(irq_req), .host_irq(host_irq), .irq_vec(irq_vec),
      .mv_valid(mv_valid), .mv_bidir(mv_bidir), .mv_h(mv_h), .mv_v(mv_v)
   );
   pvh_local_model u_pvh_local_model (
      .clock(clock), .rst_n(rst_n), .lat(lat), .loc_req(loc_req),
      .loc_we(loc_we), .loc_addr(loc_addr), .loc_wdata(loc_wdata),
      .loc_rdata(loc_rdata), .loc_ack(loc_ack)
   );
   // ********
   // Tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // One classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      if (n >= 100) begin
         err_total++;
         $display("Error at %0t: no bus answer", $time);
         tally_and_finish();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      wb(1'b0, a, 32'h0, 4'hF);
   endtask : rd
   task automatic push(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         cob_valid <= 1'b1;
         cob_data <= 32'hC0DE_0000 + i;
      end
      @(posedge clock);
      cob_valid <= 1'b0;
   endtask : push
   // ********
   // Scenarios
   // ********
   task automatic t_reset;
      chk(pw_ready, 1'b1);
      chk(cob_ready, 1'b1);
      rd(PVH_OFF_METER);
      chk(q, 32'h0);
      rd(PVH_OFF_ADDR);
      chk(q, PVH_ADDR_RST);
      rd(PVH_OFF_STAT);
      chk(q, 32'h0002_0000);
      rd(4'h2);
      chk(q, 32'h0);
   endtask : t_reset
   // Fill, refuse and drain the code buffer through the data window
   task automatic t_code;
      push(3);
      rd(PVH_OFF_METER);
      chk(q, 32'h3);
      wr(PVH_OFF_ADDR, 32'h8000_0000);
      rd(PVH_OFF_DATA);
      chk(q, 32'hC0DE_0000);
      rd(PVH_OFF_METER);
      chk(q, 32'h2);
      push(20);
      rd(PVH_OFF_METER);
      chk(q, 32'h10);
      chk(cob_ready, 1'b0);
      rd(PVH_OFF_STAT);
      chk(q[16], 1'b1);
      // Two words left over, then the fourteen taken before full
      for (int i = 0; i < 16; i++) begin
         rd(PVH_OFF_DATA);
         chk(q, (i < 2) ? 32'hC0DE_0001 + i : 32'hC0DE_0000 + i - 2);
      end
      // A read of the empty buffer must not pop below zero
      rd(PVH_OFF_DATA);
      rd(PVH_OFF_METER);
      chk(q, 32'h0);
   endtask : t_code
   // Host words reach the local bus and come back, quick and slow
   task automatic t_local;
      // Start block: rate, buffer kilobits, group 15 and distance 3,
      // program width 704, then the run flag last
      logic [31:0] prm [5] = '{32'h005B_8D80, 32'h0000_0700,
                               32'h0000_030F, 32'h0000_02C0, 32'h0000_0001};
      wr(PVH_OFF_METER, 32'hFFFF_FFFF);
      rd(PVH_OFF_METER);
      chk(q, 32'h0);
      lat <= 4'h0;
      wr(PVH_OFF_ADDR, 32'h0000_0005);
      wr(PVH_OFF_DATA, 32'hA5A5_5A5A);
      lat <= 4'h7;
      wr(PVH_OFF_ADDR, 32'h0000_0006);
      wr(PVH_OFF_DATA, 32'h1234_5678);
      wr(PVH_OFF_ADDR, 32'h0000_0005);
      rd(PVH_OFF_DATA);
      chk(q, 32'hA5A5_5A5A);
      wr(PVH_OFF_ADDR, 32'h0000_0006);
      rd(PVH_OFF_DATA);
      chk(q, 32'h1234_5678);
      for (int i = 0; i < 5; i++) begin
         wr(PVH_OFF_ADDR, 32'h0000_0008 + i);
         wr(PVH_OFF_DATA, prm[i]);
      end
      rd(PVH_OFF_DATA);
      chk(q, 32'h0000_0001);
      wr(PVH_OFF_DATA, 32'h0000_0000);
      rd(PVH_OFF_DATA);
      chk(q, 32'h0000_0000);
   endtask : t_local
   task automatic t_mbox;
      @(posedge clock);
      pw_valid <= 1'b1;
      pw_data <= 32'hBEEF_0001;
      @(posedge clock);
      pw_valid <= 1'b0;
      @(posedge clock);
      chk(pw_ready, 1'b0);
      rd(PVH_OFF_STAT);
      chk(q[6], 1'b1);
      rd(PVH_OFF_DATA);
      chk(q, 32'hBEEF_0001);
      @(posedge clock);
      chk(pw_ready, 1'b1);
   endtask : t_mbox
   task automatic t_irq;
      wr(PVH_OFF_STAT, 32'h0008_5A20);
      irq_req <= 1'b1;
      repeat (2) @(posedge clock);
      chk(host_irq, 1'b1);
      chk(irq_vec, 8'h5A);
      rd(PVH_OFF_STAT);
      chk(q & 32'h000C_FF20, 32'h000C_5A20);
      wr(PVH_OFF_STAT, 32'h0000_5A00);
      repeat (2) @(posedge clock);
      chk(host_irq, 1'b0);
      irq_req <= 1'b0;
   endtask : t_irq
   // Search limits at each edge, inside and one half-element beyond
   task automatic t_motion;
      logic signed [9:0] h [12] = '{-212, -213, 199, 200, -148, -149,
                                    135, 136, 0, 0, 0, 0};
      logic signed [9:0] v [12] = '{0, 0, 0, 0, 0, 0, 0, 0, -116, -117,
                                    103, 104};
      logic [11:0] bd = 12'h0F0;
      logic [11:0] bad = 12'h555;
      for (int i = 0; i < 12; i++) begin
         @(posedge clock);
         mv_valid <= 1'b1;
         mv_bidir <= bd[11-i];
         mv_h <= h[i];
         mv_v <= v[i];
         @(posedge clock);
         mv_valid <= 1'b0;
         rd(PVH_OFF_STAT);
         chk(q[7], bad[11-i]);
         wb(1'b1, PVH_OFF_STAT, 32'h0000_0080, 4'h1);
      end
   endtask : t_motion
   // Line 54 of a 480-line picture is the first of segment one
   task automatic t_video;
      @(posedge clock);
      vin_valid <= 1'b1;
      vin_data <= 16'h8010;
      repeat (53 * 708) @(posedge clock);
      vin_valid <= 1'b0;
      repeat (2) @(posedge clock);
      chk(seg_owner, 4'h0);
      vin_valid <= 1'b1;
      repeat (708) @(posedge clock);
      vin_valid <= 1'b0;
      repeat (2) @(posedge clock);
      chk(seg_owner, 4'h1);
      chk(stage, 5'h0);
      chk(frame_tick, 1'b0);
   endtask : t_video
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Main sequence; every input starts from a known level
   initial begin
      {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, vin_valid, cob_valid} = '0;
      {pw_valid, irq_req, mv_valid, mv_bidir} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i, cob_data, pw_data} = '0;
      {vin_data, mv_h, mv_v, lat} = '0;
      err_total = 0;
      check_count = 0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      // Readies rise at the first edge after release; look one later
      repeat (2) @(posedge clock);
      t_reset();
      t_code();
      t_local();
      t_mbox();
      t_irq();
      t_motion();
      t_video();
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
